// File: inc/cwc_pkg.sv
// Constants for the clock and wait-state control block.
// Assumes a single oscillator-rate clock and an 8-bit register port.
package cwc_pkg;
    // ************************************************
    // Register offsets
    // ************************************************
    localparam logic [2:0] CWC_OFS_STACK_PORT = 3'h3;
    localparam logic [2:0] CWC_OFS_DEV_CTRL = 3'h0;
    localparam logic [7:0] CWC_DEV_CTRL_RST = 8'h00;

    // ************************************************
    // Field positions of the device control register
    // ************************************************
    localparam int CWC_CPU_CLK_SEL_BIT = 7;
    localparam int CWC_XCVR_SEL_HI = 6;
    localparam int CWC_XCVR_SEL_LO = 5;
    localparam int CWC_IWAIT_HI = 4;
    localparam int CWC_IWAIT_LO = 3;
    localparam int CWC_DWAIT_HI = 2;
    localparam int CWC_DWAIT_LO = 0;

    // Transceiver clock source encodings
    localparam logic [1:0] CWC_XSEL_FULL = 2'h0;
    localparam logic [1:0] CWC_XSEL_HALF = 2'h1;
    localparam logic [1:0] CWC_XSEL_QUARTER = 2'h2;
    localparam logic [1:0] CWC_XSEL_EXT = 2'h3;

    // Stack geometry
    localparam int CWC_STACK_DEPTH = 16;
    localparam int CWC_STACK_PTR_W = 4;

    // Memory access state machine
    typedef enum logic [1:0] {
        CWC_ST_IDLE,
        CWC_ST_WAIT,
        CWC_ST_DONE
    } cwc_acc_state_t;
endpackage

// File: hw/cwc_wait_gen.sv
// Wait-state sequencer for one memory port.
// Assumes requests are one-cycle pulses from the oscillator clock domain.
module cwc_wait_gen
    import cwc_pkg::*;
#(
    parameter int WAIT_W = 2
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_cpu_tick,
    input wire logic i_req,
    input wire logic [WAIT_W-1:0] i_wait_count,
    output logic o_busy,
    output logic o_done
);
    import cwc_pkg::*;

    cwc_acc_state_t state_ff, nxt_state;
    logic [WAIT_W-1:0] cnt_ff, nxt_cnt;

    // ************************************************
    // Count one processor period per wait state
    // ************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            CWC_ST_IDLE: begin
                if (i_req) begin
                    nxt_cnt = i_wait_count;
                    nxt_state = CWC_ST_WAIT;
                end
            end
            CWC_ST_WAIT: begin
                if (i_cpu_tick) begin
                    if (cnt_ff == '0) begin
                        nxt_state = CWC_ST_DONE;
                    end else begin
                        nxt_cnt = cnt_ff - 1'b1;
                    end
                end
            end
            CWC_ST_DONE: begin
                nxt_state = CWC_ST_IDLE;
            end
            default: begin
                nxt_state = CWC_ST_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= CWC_ST_IDLE;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Handshake outputs
    assign o_busy = (state_ff == CWC_ST_WAIT);
    assign o_done = (state_ff == CWC_ST_DONE);
endmodule

// File: hw/cwc_clock_wait_ctrl.sv
// Device control register, clock enables, wait states and byte stack.
// Assumes i_ref_clk is the oscillator clock; register port is 8 bits.
// The external transceiver clock arrives on a pin and is synchronised.
// Register strobes and memory requests come from the oscillator clock.
module cwc_clock_wait_ctrl
    import cwc_pkg::*;
#(
    parameter int DEPTH = cwc_pkg::CWC_STACK_DEPTH,
    parameter int PTR_W = cwc_pkg::CWC_STACK_PTR_W
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [2:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_external_xcvr_clock_in,
    input wire logic i_imem_req,
    input wire logic i_dmem_req,
    output logic o_cpu_tick,
    output logic o_xcvr_clock,
    output logic o_imem_busy,
    output logic o_imem_done,
    output logic o_dmem_busy,
    output logic o_dmem_done,
    output logic o_stack_empty,
    output logic o_stack_full
);
    import cwc_pkg::*;

    // ************************************************
    // Register storage
    // ************************************************
    logic [7:0] dev_ctrl_ff;
    logic [7:0] stack_mem [DEPTH];
    logic [PTR_W:0] sp_ff, nxt_sp;
    logic [7:0] rdata_ff, nxt_rdata;
    logic div_ff;
    logic [2:0] xdiv_ff;
    logic ext_s1_ff, ext_s2_ff;
    logic xclk_ff, nxt_xclk;

    // Field decode
    wire logic cpu_half = dev_ctrl_ff[CWC_CPU_CLK_SEL_BIT];
    wire logic [1:0] xcvr_clock_select =
        dev_ctrl_ff[CWC_XCVR_SEL_HI:CWC_XCVR_SEL_LO];
    wire logic [1:0] instr_mem_wait_count =
        dev_ctrl_ff[CWC_IWAIT_HI:CWC_IWAIT_LO];
    wire logic [2:0] data_mem_wait_count =
        dev_ctrl_ff[CWC_DWAIT_HI:CWC_DWAIT_LO];

    // True when the register index selects the given register
    function automatic logic hit_reg(input logic [2:0] addr,
        input logic [2:0] ofs);
        hit_reg = (addr == ofs);
    endfunction

    // ************************************************
    // Address decode
    // ************************************************
    wire logic sel_ctrl = hit_reg(i_reg_addr, CWC_OFS_DEV_CTRL);
    wire logic sel_stack = hit_reg(i_reg_addr, CWC_OFS_STACK_PORT);
    // Full compares at PTR_W+1 bits, so the depth is not truncated
    wire logic stk_full = (sp_ff == (PTR_W+1)'(DEPTH));
    wire logic stk_empty = (sp_ff == '0);
    wire logic push = i_reg_wr && sel_stack && !stk_full;
    wire logic pop = i_reg_rd && sel_stack && !stk_empty;

    // ************************************************
    // Control register write
    // ************************************************
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dev_ctrl_ff <= CWC_DEV_CTRL_RST;
        end else if (i_reg_wr && sel_ctrl) begin
            // Stack writes use their own index and never reach the fields
            dev_ctrl_ff <= i_reg_wdata;
        end
    end

    // ************************************************
    // Processor clock enable
    // ************************************************
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_ff <= 1'b0;
            xdiv_ff <= '0;
        end else begin
            div_ff <= ~div_ff;
            // Counter bits give the half and quarter rate waveforms
            xdiv_ff <= xdiv_ff + 3'h1;
        end
    end
    // At half rate the tick is high on every second oscillator edge
    assign o_cpu_tick = cpu_half ? div_ff : 1'b1;

    // ************************************************
    // Transceiver clock selection
    // ************************************************
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
        end else begin
            // Only the second flop feeds the clock selector
            ext_s1_ff <= i_external_xcvr_clock_in;
            ext_s2_ff <= ext_s1_ff;
        end
    end

    // Full rate toggles each edge, a square wave at half the oscillator rate
    always_comb begin
        case (xcvr_clock_select)
            CWC_XSEL_FULL: nxt_xclk = ~xclk_ff;
            CWC_XSEL_HALF: nxt_xclk = xdiv_ff[1];
            CWC_XSEL_QUARTER: nxt_xclk = xdiv_ff[2];
            CWC_XSEL_EXT: nxt_xclk = ext_s2_ff;
            default: nxt_xclk = 1'b0;
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            xclk_ff <= 1'b0;
        end else begin
            // Registered so the transceiver never sees a select glitch
            xclk_ff <= nxt_xclk;
        end
    end
    assign o_xcvr_clock = xclk_ff;

    // ************************************************
    // Wait-state sequencers
    // ************************************************
    // Both ports count processor ticks, so half rate stretches every
    // wait state as well as the base access
    cwc_wait_gen #(.WAIT_W(2)) u_imem_wait (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_cpu_tick(o_cpu_tick),
        .i_req(i_imem_req),
        .i_wait_count(instr_mem_wait_count),
        .o_busy(o_imem_busy),
        .o_done(o_imem_done)
    );

    cwc_wait_gen #(.WAIT_W(3)) u_dmem_wait (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_cpu_tick(o_cpu_tick),
        .i_req(i_dmem_req),
        .i_wait_count(data_mem_wait_count),
        .o_busy(o_dmem_busy),
        .o_done(o_dmem_done)
    );

    // ************************************************
    // Byte stack behind the stack port
    // ************************************************
    // Overflowing pushes and underflowing pops are dropped; the pointer
    // has one spare bit so that full and empty stay distinct
    always_comb begin
        nxt_sp = sp_ff;
        if (push) begin
            nxt_sp = sp_ff + 1'b1;
        end else if (pop) begin
            nxt_sp = sp_ff - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            stack_mem[sp_ff[PTR_W-1:0]] <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sp_ff <= '0;
        end else begin
            sp_ff <= nxt_sp;
        end
    end

    // Read data: top of stack on pop, control register at its own index
    // Unmapped indexes and an empty stack read back as zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (i_reg_rd) begin
            if (sel_ctrl) begin
                nxt_rdata = dev_ctrl_ff;
            end else if (pop) begin
                nxt_rdata = stack_mem[PTR_W'(sp_ff - 1'b1)];
            end else begin
                nxt_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ************************************************
    // Outputs
    // ************************************************
    assign o_reg_rdata = rdata_ff;
    assign o_stack_empty = stk_empty;
    assign o_stack_full = stk_full;
endmodule

// File: testbench/cwc_clock_wait_ctrl_asserts.sv
// Assertions for the clock and wait-state control block.
// Assumes binding to cwc_clock_wait_ctrl; one clock domain.
module cwc_clock_wait_ctrl_asserts (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [2:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_external_xcvr_clock_in,
    input wire logic i_imem_req,
    input wire logic i_dmem_req,
    input wire logic o_cpu_tick,
    input wire logic o_xcvr_clock,
    input wire logic o_imem_busy,
    input wire logic o_imem_done,
    input wire logic o_dmem_busy,
    input wire logic o_dmem_done,
    input wire logic o_stack_empty,
    input wire logic o_stack_full
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] ctrl_ff, icnt_ff, dcnt_ff;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    // Control shadow and cycles since each request
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl_ff <= 8'h00;
            icnt_ff <= 8'h00;
            dcnt_ff <= 8'h00;
        end else begin
            if (i_reg_wr && i_reg_addr == 3'h0) begin
                ctrl_ff <= i_reg_wdata;
            end
            icnt_ff <= i_imem_req ? 8'h01 : icnt_ff + 8'h01;
            dcnt_ff <= i_dmem_req ? 8'h01 : dcnt_ff + 8'h01;
        end
    end
    cpu_full_a: assert property (!ctrl_ff[7] |-> o_cpu_tick)
        else $error("cpu tick low at full rate");
    cpu_half_a: assert property (ctrl_ff[7] && $past(ctrl_ff[7]) |=>
        o_cpu_tick != $past(o_cpu_tick) || !ctrl_ff[7])
        else $error("cpu tick not alternating");
    xcvr_full_a: assert property (ctrl_ff[6:5] == 2'h0 &&
        $past(ctrl_ff[6:5]) == 2'h0 |=>
        o_xcvr_clock != $past(o_xcvr_clock) || ctrl_ff[6:5] != 2'h0)
        else $error("xcvr clock not toggling");
    xcvr_ext_a: assert property (ctrl_ff[6:5] == 2'h3 &&
        $rose(i_external_xcvr_clock_in) |-> ##[2:4] o_xcvr_clock)
        else $error("xcvr clock not following pin");
    imem_wait_a: assert property (o_imem_done && !ctrl_ff[7] |->
        icnt_ff == {6'h00, ctrl_ff[4:3]} + 8'h02)
        else $error("imem wait length wrong");
    dmem_wait_a: assert property (o_dmem_done && !ctrl_ff[7] |->
        dcnt_ff == {5'h00, ctrl_ff[2:0]} + 8'h02)
        else $error("dmem wait length wrong");
    imem_busy_a: assert property (i_imem_req && !o_imem_busy &&
        !o_imem_done |=> o_imem_busy)
        else $error("imem not busy after request");
    dmem_busy_a: assert property (i_dmem_req && !o_dmem_busy &&
        !o_dmem_done |=> o_dmem_busy)
        else $error("dmem not busy after request");
    stack_flags_a: assert property (o_stack_full |-> !o_stack_empty)
        else $error("stack full and empty");
endmodule
bind cwc_clock_wait_ctrl cwc_clock_wait_ctrl_asserts u_asserts (
    .i_ref_clk, .i_resetn, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
    .i_external_xcvr_clock_in, .i_imem_req, .i_dmem_req, .o_cpu_tick,
    .o_xcvr_clock, .o_imem_busy, .o_imem_done, .o_dmem_busy, .o_dmem_done,
    .o_stack_empty, .o_stack_full
);

// File: testbench/clock_and_wait_state_control_bench.sv
// Self-checking bench for the clock and wait-state control block.
// Assumes the package, design and checker are compiled first.
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin \
    mismatches++; $display("mismatch at %0t: %h not %h", $time, a, e); \
    end end
module clock_and_wait_state_control_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cwc_pkg::*;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, ext = 0, ireq = 0, dreq = 0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, d, e8;
    logic tick, xclk, ibusy, idone, dbusy, ddone, emp, full, b;
    int mismatches = 0, n_checks = 0, cyc = 0, c, tog;
    int xe[4] = '{32, 16, 8, 8};
    logic [7:0] q[$];
    cwc_clock_wait_ctrl dut (.i_ref_clk(clk), .i_resetn(rstn),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_external_xcvr_clock_in(ext), .i_imem_req(ireq),
        .i_dmem_req(dreq), .o_cpu_tick(tick), .o_xcvr_clock(xclk),
        .o_imem_busy(ibusy), .o_imem_done(idone), .o_dmem_busy(dbusy),
        .o_dmem_done(ddone), .o_stack_empty(emp), .o_stack_full(full));
    initial forever #12.5 clk = ~clk;
    // Cycle ceiling and a slow external transceiver clock
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3) ext <= ~ext;
        if (cyc == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // One memory access; c counts cycles from request to done
    task automatic acc(input logic dm);
        @(posedge clk);
        dreq <= dm;
        ireq <= !dm;
        @(posedge clk);
        dreq <= 1'b0;
        ireq <= 1'b0;
        #1 `CHK(dm ? dbusy : ibusy, 1'b1)
        c = 1;
        do begin
            @(posedge clk);
            #1 c++;
        end while (!(dm ? ddone : idone) && c < 40);
    endtask
    initial begin
        c = $urandom(32'ha8a666f5);
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        e8 = $urandom;
        wreg(CWC_OFS_DEV_CTRL, e8);
        rreg(CWC_OFS_DEV_CTRL);
        `CHK(d, e8)
        wreg(3'h5, 8'hff);
        rreg(3'h5);
        `CHK(d, 8'h00)
        $display("registers done");
        for (int i = 0; i < 17; i++) begin
            e8 = $urandom;
            wreg(CWC_OFS_STACK_PORT, e8);
            if (q.size() < 16) q.push_back(e8);
        end
        #1 `CHK(full, 1'b1)
        for (int i = 0; i < 17; i++) begin
            rreg(CWC_OFS_STACK_PORT);
            e8 = q.size() ? q.pop_back() : 8'h00;
            `CHK(d, e8)
        end
        `CHK(emp, 1'b1)
        $display("stack done");
        for (int n = 0; n < 8; n++) begin
            wreg(CWC_OFS_DEV_CTRL, 8'(n) | 8'((n % 4) << 3));
            acc(1'b1);
            `CHK(c, n + 2)
            acc(1'b0);
            `CHK(c, n % 4 + 2)
        end
        wreg(CWC_OFS_DEV_CTRL, 8'h9f);
        acc(1'b1);
        `CHK(c >= 16 && c <= 19, 1'b1)
        $display("wait states done");
        foreach (xe[s]) begin
            wreg(CWC_OFS_DEV_CTRL, 8'(s << 5));
            repeat (6) @(posedge clk);
            #1 tog = 0;
            repeat (32) begin
                b = xclk;
                @(posedge clk);
                #1 if (xclk !== b) tog++;
            end
            `CHK(tog >= xe[s] - 1 && tog <= xe[s] + 1, 1'b1)
        end
        $display("xcvr clock done");
        give_verdict();
    end
endmodule
